// ### ibac_pkg.sv
// Package of constants and types for the instrument bus addressing controller
package ibac_pkg;

  // ----------------------------------------------------------------
  // Bus addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_MAX      = 5'h1e;  // Highest usable primary address
  localparam logic [2:0] GRP_LISTEN    = 3'h1;   // Listen address group, bits 7:5
  localparam logic [2:0] GRP_TALK      = 3'h2;   // Talk address group, bits 7:5
  localparam logic [7:0] CMD_UNLISTEN  = 8'h3f;
  localparam logic [7:0] CMD_UNTALK    = 8'h5f;

  // ----------------------------------------------------------------
  // Error codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] ERR_NONE       = 5'h00;
  localparam logic [4:0] ERR_NOT_TALKER = 5'h0f;  // 15
  localparam logic [4:0] ERR_NOT_LISTEN = 5'h10;  // 16
  localparam logic [4:0] ERR_BAD_ADDR   = 5'h11;  // Target outside 0..30
  localparam logic [4:0] MY_ADDR_RST    = 5'h00;

  // ----------------------------------------------------------------
  // Handshake timing
  // ----------------------------------------------------------------
  localparam int          SETTLE_NS     = 8;      // Data hold after DAV drops
  localparam int          CLK_NS        = 8;
  localparam logic [3:0]  SETTLE_CYC    = 4'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Request kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] REQ_OUT        = 2'h0;  // Addressed output to one target
  localparam logic [1:0] REQ_IN         = 2'h1;  // Addressed input from one target
  localparam logic [1:0] REQ_LISTEN_ADD = 2'h2;  // Add a listener only
  localparam logic [1:0] REQ_PASS       = 2'h3;  // Pass active control

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_CMD  = 8'b0000_0010,
    ST_SRC  = 8'b0000_0100,
    ST_ACC  = 8'b0000_1000,
    ST_WAIT = 8'b0001_0000,
    ST_DONE = 8'b0010_0000,
    ST_ERR  = 8'b0100_0000,
    ST_PASS = 8'b1000_0000
  } ibac_state_type;

endpackage

// ### ibac_top.sv
// Addressing, controller role and byte handshake of an instrument bus port
//
// Operation
// - Primary addresses 0..30 only, 31 never selects
// - ATN held true throughout addressing commands
// - ATN true means command, false means data
// - Unlisten, one talker, listeners, then release ATN
// - Only addressed listeners take data bytes
// - Byte completes when every listener accepted
// - System controller becomes active controller after reset
// - System controller role from strap pin only
// - Control can be passed; strap role unchanged
// - Output: unlisten, own talk, target listen, data
// - Input: unlisten, target talk, own listen, data
// - Several listen addresses after one talk address
// - Non-controller or unaddressed request sends no addressing; a controller's pass still sends the target's talk address
// - Non-controller waits until addressed, then transfers
// - Controller unaddressed transfer keeps current configuration
// - Controller not addressed reports error 15/16
`timescale 1ns/1ns
module ibac_top (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  // Straps
  input  wire logic                  sys_ctrl_strap,
  input  wire logic [4:0]            my_addr,
  // Request from host
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire logic [1:0]            req_kind,
  input  wire logic                  req_addressed,
  input  wire logic [4:0]            req_target,
  // Outgoing data stream
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  input  wire logic [7:0]            tx_data,
  input  wire logic                  tx_last,
  // Incoming data stream
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  output logic [7:0]                 rx_data,
  // Completion
  output logic                       done_pulse,
  output logic [4:0]                 err_code_ff,
  output logic                       active_ctrl,
  output logic                       talker,
  output logic                       listener,
  // Bus pins, open collector, low true, oe low while driving
  input  wire logic [7:0]            dio_i,
  output logic [7:0]                 dio_o,
  output logic [7:0]                 dio_oe_n,
  input  wire logic                  atn_i,
  output logic                       atn_o,
  output logic                       atn_oe_n,
  input  wire logic                  dav_i,
  output logic                       dav_o,
  output logic                       dav_oe_n,
  input  wire logic                  nrfd_i,
  output logic                       nrfd_o,
  output logic                       nrfd_oe_n,
  input  wire logic                  ndac_i,
  output logic                       ndac_o,
  output logic                       ndac_oe_n
);
  import ibac_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ibac_state_type state_ff, nxt_state;
  logic       ac_ff, nxt_ac;
  logic       sc_ff;
  logic       strap_done_ff;
  logic       talk_ff, nxt_talk;
  logic       lstn_ff, nxt_lstn;
  logic [1:0] kind_ff;
  logic [4:0] tgt_ff;
  logic [1:0] step_ff, nxt_step;
  logic [7:0] byte_ff;
  logic       last_ff;
  logic       src_ph_ff;     // 0: waiting for ready, 1: DAV asserted
  logic [3:0] settle_ff;
  logic       acc_ph_ff;     // 1: byte latched, holding NRFD
  logic [4:0] nxt_err;
  logic       cmd_mode;
  // Two-entry receive buffer
  logic [7:0] buf_mem [2];
  logic       wr_ptr_ff, rd_ptr_ff;
  logic [1:0] cnt_ff;

  // ----------------------------------------------------------------
  // Bus decode (pins low true)
  // ----------------------------------------------------------------
  wire        atn_true   = ~atn_i;
  wire        dav_true   = ~dav_i;
  wire        nrfd_true  = ~nrfd_i;   // Wired-AND: any listener not ready
  wire        ndac_true  = ~ndac_i;   // Wired-AND: any listener not done
  wire [7:0]  bus_byte   = ~dio_i;
  wire [4:0]  bus_addr   = bus_byte[4:0];
  wire        to_me      = (bus_addr == my_addr) && (my_addr <= ADDR_MAX);
  wire        is_unl     = bus_byte == CMD_UNLISTEN;
  wire        is_unt     = bus_byte == CMD_UNTALK;
  wire        is_lad     = (bus_byte[7:5] == GRP_LISTEN) && !is_unl;
  wire        is_tad     = (bus_byte[7:5] == GRP_TALK) && !is_unt;
  wire        tgt_ok     = req_target <= ADDR_MAX;
  wire        buf_full   = cnt_ff == 2'h2;
  wire        need_talk  = (req_kind == REQ_OUT);
  wire        role_ok    = need_talk ? talk_ff : lstn_ff;
  wire        idle       = state_ff == ST_IDLE;
  wire        go         = idle && req_valid;
  // Commands and data bytes both end when the last acceptor lets NDAC go
  wire        src_done   = (cmd_mode || state_ff == ST_SRC) && src_ph_ff && !ndac_true;
  wire        cmd_last   = (kind_ff == REQ_LISTEN_ADD) ? 1'b1 : (step_ff == 2'h2);
  wire        accepting  = (state_ff == ST_ACC) || (state_ff == ST_IDLE && lstn_ff && !atn_true && !cmd_mode);
  wire        acc_ok     = accepting || atn_true;
  wire        take_byte  = dav_true && !acc_ph_ff && (atn_true || (lstn_ff && accepting && !buf_full));
  wire        acc_release = acc_ph_ff && !dav_true;

  // Addressing byte sequence, chosen by step
  logic [7:0] cmd_byte;
  always_comb begin
    cmd_byte = CMD_UNLISTEN;
    if (kind_ff == REQ_LISTEN_ADD) begin
      cmd_byte = {GRP_LISTEN, tgt_ff};
    end else if (step_ff == 2'h1) begin
      cmd_byte = (kind_ff == REQ_OUT) ? {GRP_TALK, my_addr} : {GRP_TALK, tgt_ff};
    end else if (step_ff == 2'h2) begin
      cmd_byte = (kind_ff == REQ_OUT) ? {GRP_LISTEN, tgt_ff} : {GRP_LISTEN, my_addr};
    end
  end

  // ----------------------------------------------------------------
  // Control flow
  // ----------------------------------------------------------------
  // Addressing only when active controller and a target was given
  always_comb begin
    nxt_state = state_ff;
    nxt_step  = step_ff;
    nxt_ac    = ac_ff;
    nxt_err   = err_code_ff;
    unique case (state_ff)
      ST_IDLE: if (req_valid) begin
        nxt_err = ERR_NONE;
        if (req_kind == REQ_PASS) begin
          nxt_state = ac_ff && tgt_ok ? ST_PASS : ST_ERR;
        end else if (req_addressed && ac_ff) begin
          nxt_step  = 2'h0;
          nxt_state = tgt_ok ? ST_CMD : ST_ERR;
          if (!tgt_ok) nxt_err = ERR_BAD_ADDR;
        end else if (req_kind == REQ_LISTEN_ADD) begin
          nxt_state = ST_ERR;
        end else if (!ac_ff) begin
          nxt_state = ST_WAIT;
        end else if (role_ok) begin
          nxt_state = need_talk ? ST_SRC : ST_ACC;
        end else begin
          nxt_state = ST_ERR;
          nxt_err   = need_talk ? ERR_NOT_TALKER : ERR_NOT_LISTEN;
        end
      end
      ST_CMD: if (src_done) begin
        nxt_step = step_ff + 2'h1;
        if (cmd_last) begin
          nxt_state = (kind_ff == REQ_LISTEN_ADD) ? ST_DONE :
                      (kind_ff == REQ_OUT) ? ST_SRC : ST_ACC;
        end
      end
      ST_SRC: if (src_done && last_ff) nxt_state = ST_DONE;
      ST_ACC: if (acc_release && last_ff) nxt_state = ST_DONE;
      ST_WAIT: if ((kind_ff == REQ_OUT) ? talk_ff : lstn_ff) begin
        nxt_state = (kind_ff == REQ_OUT) ? ST_SRC : ST_ACC;
      end
      ST_PASS: if (src_done) begin
        nxt_ac    = 1'b0;
        nxt_state = ST_DONE;
      end
      ST_DONE: nxt_state = ST_IDLE;
      ST_ERR:  nxt_state = ST_IDLE;
    endcase
  end

  // Own talker/listener state follows commands seen with ATN true
  always_comb begin
    nxt_talk = talk_ff;
    nxt_lstn = lstn_ff;
    if (dav_true && atn_true && !acc_ph_ff) begin
      if (is_unl) nxt_lstn = 1'b0;
      if (is_unt) nxt_talk = 1'b0;
      if (is_lad && to_me) nxt_lstn = 1'b1;
      if (is_tad) nxt_talk = to_me;
    end
  end

  // Strap sampled after release; a controller takes the active role
  // The strap copy never changes after that, whatever control passing does
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strap_done_ff <= 1'b0;
      sc_ff         <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      sc_ff         <= sys_ctrl_strap;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      step_ff     <= 2'h0;
      err_code_ff <= ERR_NONE;
      talk_ff     <= 1'b0;
      lstn_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      step_ff     <= nxt_step;
      err_code_ff <= nxt_err;
      talk_ff     <= nxt_talk;
      lstn_ff     <= nxt_lstn;
    end
  end

  // Active role: from strap once, then only passing clears it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ac_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      ac_ff <= sys_ctrl_strap;
    end else begin
      ac_ff <= nxt_ac;
    end
  end

  // Request capture
  // Kind and target are kept, so the host may drop its request once taken
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      kind_ff <= REQ_OUT;
      tgt_ff  <= MY_ADDR_RST;
    end else if (go) begin
      kind_ff <= req_kind;
      tgt_ff  <= req_target;
    end
  end

  // ----------------------------------------------------------------
  // Source handshake: load byte with DAV, wait NDAC release, settle
  // ----------------------------------------------------------------
  // A new byte goes out only with NRFD released and NDAC held, so every
  // acceptor is present and ready; data with no listener addressed stall
  // here until one appears. Under ATN our own acceptor holds NDAC.
  // Data stay driven through the settle count after DAV drops while the state stays CMD, SRC or PASS.
  wire src_busy = (state_ff == ST_CMD) || (state_ff == ST_SRC) || (state_ff == ST_PASS);
  wire src_load = src_busy && !src_ph_ff && settle_ff == 4'h0 && !nrfd_true && ndac_true;
  wire data_in  = (state_ff == ST_SRC) && !src_ph_ff && settle_ff == 4'h0;
  assign cmd_mode = (state_ff == ST_CMD) || (state_ff == ST_PASS);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_ph_ff <= 1'b0;
      settle_ff <= 4'h0;
      byte_ff   <= 8'h00;
      last_ff   <= 1'b0;
    end else if (src_done) begin
      src_ph_ff <= 1'b0;
      settle_ff <= SETTLE_CYC;
    end else if (settle_ff != 4'h0) begin
      settle_ff <= settle_ff - 4'h1;
    end else if (src_load && (cmd_mode || tx_valid)) begin
      src_ph_ff <= 1'b1;
      byte_ff   <= (state_ff == ST_PASS) ? {GRP_TALK, tgt_ff} : cmd_mode ? cmd_byte : tx_data;
      last_ff   <= cmd_mode ? 1'b0 : tx_last;
    end else if (state_ff == ST_ACC && acc_release) begin
      last_ff   <= 1'b0;
    end
  end
  assign tx_ready = src_load && data_in;

  // ----------------------------------------------------------------
  // Acceptor: NRFD until room, NDAC until byte latched (wired-AND)
  // ----------------------------------------------------------------
  // Every command sourced here under ATN is also taken here, which is
  // how the talker and listener flags follow our own addressing
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_ph_ff <= 1'b0;
    end else if (take_byte) begin
      acc_ph_ff <= 1'b1;
    end else if (acc_release) begin
      acc_ph_ff <= 1'b0;
    end
  end

  // Receive buffer: a stalled reader holds NRFD so no byte is lost
  // Two entries let the acceptor take one more byte while the reader stalls
  wire push = take_byte && !atn_true && lstn_ff;
  wire pop  = rx_valid && rx_ready;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff    <= 2'h0;
    end else begin
      if (push) wr_ptr_ff <= ~wr_ptr_ff;
      if (pop)  rd_ptr_ff <= ~rd_ptr_ff;
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) buf_mem[wr_ptr_ff] <= bus_byte;
  end
  assign rx_valid = cnt_ff != 2'h0;
  assign rx_data  = buf_mem[rd_ptr_ff];

  // ----------------------------------------------------------------
  // Pin drive: oe low while pulling the line true (low)
  // ----------------------------------------------------------------
  wire drive_dio  = src_ph_ff || (src_busy && settle_ff != 4'h0);
  wire hold_nrfd  = (lstn_ff || atn_true) && (acc_ph_ff || buf_full || !acc_ok);
  wire hold_ndac  = (lstn_ff || atn_true) && !acc_ph_ff;
  assign dio_o     = 8'h00;
  assign dio_oe_n  = drive_dio ? ~byte_ff : 8'hff;
  assign atn_o     = 1'b0;
  assign atn_oe_n  = ~(ac_ff && cmd_mode);
  assign dav_o     = 1'b0;
  assign dav_oe_n  = ~src_ph_ff;
  assign nrfd_o    = 1'b0;
  assign nrfd_oe_n = ~hold_nrfd;
  assign ndac_o    = 1'b0;
  assign ndac_oe_n = ~hold_ndac;

  // Status
  // done_pulse marks good ends and refusals alike, one cycle each
  assign req_ready   = idle;
  assign done_pulse  = (state_ff == ST_DONE) || (state_ff == ST_ERR);
  assign active_ctrl = ac_ff;
  assign talker      = talk_ff;
  assign listener    = lstn_ff;

endmodule

// ### ibac_chk_sva.sv
// Port checker for the instrument bus addressing controller
`timescale 1ns/1ns
module ibac_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // Host side
  input wire logic       sys_ctrl_strap,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [1:0] req_kind,
  input wire logic       req_addressed,
  input wire logic [4:0] req_target,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic       done_pulse,
  input wire logic [4:0] err_code_ff,
  input wire logic       active_ctrl,
  // Bus side
  input wire logic [7:0] dio_oe_n,
  input wire logic       atn_oe_n,
  input wire logic       dav_oe_n,
  input wire logic       nrfd_i,
  input wire logic       ndac_i
);
  import ibac_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire take = req_valid && req_ready;
  // ------------------------------------------------------------
  // Roles, handshake and errors
  // ------------------------------------------------------------
  property p_strap_role; !$past(rstn) |-> ##2 (active_ctrl == sys_ctrl_strap); endproperty
  a_strap_role: assert property (p_strap_role) else $error("role after reset differs from strap");
  property p_dav_ready; $fell(dav_oe_n) |-> $past(nrfd_i); endproperty
  a_dav_ready: assert property (p_dav_ready) else $error("DAV raised while not ready");
  property p_dav_hold; !dav_oe_n && !ndac_i |=> !dav_oe_n; endproperty
  a_dav_hold: assert property (p_dav_hold) else $error("DAV dropped before all accepted");
  property p_dio_stable; !dav_oe_n && $past(!dav_oe_n) |-> $stable(dio_oe_n); endproperty
  a_dio_stable: assert property (p_dio_stable) else $error("data changed under DAV");
  property p_no_atn; !active_ctrl && $past(!active_ctrl) |-> atn_oe_n; endproperty
  a_no_atn: assert property (p_no_atn) else $error("ATN driven without control");
  property p_idle_bus; req_ready |-> dav_oe_n; endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("byte in flight while idle");
  property p_err_clear; take |=> done_pulse || err_code_ff == ERR_NONE; endproperty
  a_err_clear: assert property (p_err_clear) else $error("error code kept over new request");
  property p_err_done; $changed(err_code_ff) && err_code_ff != ERR_NONE |-> done_pulse; endproperty
  a_err_done: assert property (p_err_done) else $error("error code set without completion");
  property p_bad_addr;
    take && req_kind == REQ_OUT && req_addressed && req_target > ADDR_MAX && active_ctrl
      |-> ##[1:3] done_pulse ##[0:1] err_code_ff == ERR_BAD_ADDR;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("address 31 not refused");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("stalled receive word lost");
  // Main scenarios seen
  c_out: cover property (take && req_kind == REQ_OUT && req_addressed);
  c_pass: cover property ($fell(active_ctrl));
  c_stall: cover property (rx_valid && !rx_ready);
endmodule

// ### ibac_bus_model.sv
// Behavioural instrument on the far side of the bus: acceptor and talker
`timescale 1ns/1ns
module ibac_bus_model #(
  parameter logic [4:0] ADDR = 5'h01
) (
  // Clock, reset and acceptance delay
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic [3:0] lag,
  // Bus lines, high when released
  input  wire logic       atn_l,
  input  wire logic       dav_l,
  input  wire logic       nrfd_l,
  input  wire logic       ndac_l,
  input  wire logic [7:0] dio_l,
  // Pulls, high pulls the line low
  output logic            nrfd_pull,
  output logic            ndac_pull,
  output logic            dav_pull,
  output logic [7:0]      dio_pull,
  // Accepted byte log
  output logic            got_stb,
  output logic            got_cmd,
  output logic [7:0]      got_byte
);
  import ibac_pkg::*;
  logic       lsn_ff, tlk_ff, done_ff;
  logic [3:0] cnt_ff;
  logic [1:0] ph_ff;
  logic [7:0] src_ff;
  wire  [7:0] byte_in = ~dio_l;
  wire        acc = !atn_l || lsn_ff;
  // Acceptor holds NDAC until its own delay runs out, so the slowest sets the pace
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {lsn_ff, tlk_ff, done_ff, nrfd_pull, ndac_pull, got_stb, got_cmd} <= '0;
      cnt_ff <= '0;
      got_byte <= '0;
    end else begin
      got_stb <= 1'b0;
      if (!acc) begin
        {nrfd_pull, ndac_pull, done_ff} <= '0;
      end else if (dav_l) begin
        {nrfd_pull, done_ff} <= '0;
        cnt_ff <= '0;
        ndac_pull <= 1'b1;
      end else if (!done_ff) begin
        nrfd_pull <= 1'b1;
        cnt_ff <= cnt_ff + 4'h1;
        if (cnt_ff >= lag) begin
          done_ff <= 1'b1;
          ndac_pull <= 1'b0;
          got_stb <= 1'b1;
          got_cmd <= !atn_l;
          got_byte <= byte_in;
          if (!atn_l && byte_in == CMD_UNLISTEN) lsn_ff <= 1'b0;
          if (!atn_l && byte_in == {GRP_LISTEN, ADDR}) lsn_ff <= 1'b1;
          if (!atn_l && byte_in[7:5] == GRP_TALK) tlk_ff <= byte_in[4:0] == ADDR;
        end
      end
    end
  end
  // Talker: one settle cycle, then waits for every acceptor present and ready
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= 2'h0;
      dav_pull <= 1'b0;
      dio_pull <= '0;
      src_ff <= {3'h5, ADDR};
    end else if (!tlk_ff || !atn_l) begin
      ph_ff <= 2'h0;
      dav_pull <= 1'b0;
      dio_pull <= '0; // Released lines float high
    end else begin
      case (ph_ff)
        2'h0: begin
          dio_pull <= src_ff;
          ph_ff <= 2'h1;
        end
        2'h1: if (nrfd_l && !ndac_l) begin
          dav_pull <= 1'b1;
          ph_ff <= 2'h2;
        end
        default: if (ndac_l) begin
          dav_pull <= 1'b0;
          dio_pull <= '0;
          src_ff <= src_ff + 8'h01;
          ph_ff <= 2'h0;
        end
      endcase
    end
  end
endmodule

// ### tb_ibac_top.sv
// Self-checking bench for the instrument bus addressing controller
`timescale 1ns/1ns
module tb_ibac_top;
  import ibac_pkg::*;
  localparam logic [4:0] MY = 5'h15;
  localparam logic [4:0] AA = 5'h03;
  localparam logic [4:0] AB = ADDR_MAX; // Highest legal address on the second instrument
  logic        clk_sys = 0, rstn = 0, sys_ctrl_strap = 1, req_valid = 0, req_addressed = 0;
  logic        tx_valid = 0, tx_last = 0, rx_ready = 0, tx_ready, req_ready, rx_valid;
  logic        done_pulse, active_ctrl, talker, listener, atn_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n;
  logic        atn_i, dav_i, nrfd_i, ndac_i, pa_nrfd, pa_ndac, pa_dav, pb_nrfd, pb_ndac, pb_dav;
  logic        a_stb, a_cmd, b_stb, b_cmd;
  logic [1:0]  req_kind = 0;
  logic [3:0]  lag_a = 0;
  logic [4:0]  req_target = 0, err_code_ff;
  logic [7:0]  tx_data = 0, rx_data, dio_oe_n, dio_i, pa_dio, pb_dio, a_byte, b_byte;
  logic [15:0] rnd = 16'hca11, rs = 16'hca11;
  logic [7:0]  tx_q[$], cmd_q[$], a_dat[$], b_dat[$], rx_got[$], exp_q[$], no_q[$];
  int          n_mismatch = 0, n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  // Wired-AND bus: a line is high unless some party pulls it
  assign atn_i = atn_oe_n;
  assign dav_i = dav_oe_n & ~pa_dav & ~pb_dav;
  assign nrfd_i = nrfd_oe_n & ~pa_nrfd & ~pb_nrfd;
  assign ndac_i = ndac_oe_n & ~pa_ndac & ~pb_ndac;
  assign dio_i = dio_oe_n & ~pa_dio & ~pb_dio;
  ibac_top ibac_top_i (.clk_sys, .rstn, .sys_ctrl_strap, .my_addr(MY), .req_valid, .req_ready, .req_kind,
    .req_addressed, .req_target, .tx_valid, .tx_ready, .tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data,
    .done_pulse, .err_code_ff, .active_ctrl, .talker, .listener, .dio_i, .dio_o(), .dio_oe_n, .atn_i,
    .atn_o(), .atn_oe_n, .dav_i, .dav_o(), .dav_oe_n, .nrfd_i, .nrfd_o(), .nrfd_oe_n, .ndac_i,
    .ndac_o(), .ndac_oe_n);
  ibac_bus_model #(.ADDR(AA)) ibac_bus_model_a (.clk_sys, .rstn, .lag(lag_a), .atn_l(atn_i), .dav_l(dav_i),
    .nrfd_l(nrfd_i), .ndac_l(ndac_i), .dio_l(dio_i), .nrfd_pull(pa_nrfd), .ndac_pull(pa_ndac),
    .dav_pull(pa_dav), .dio_pull(pa_dio), .got_stb(a_stb), .got_cmd(a_cmd), .got_byte(a_byte));
  ibac_bus_model #(.ADDR(AB)) ibac_bus_model_b (.clk_sys, .rstn, .lag(4'h6), .atn_l(atn_i), .dav_l(dav_i),
    .nrfd_l(nrfd_i), .ndac_l(ndac_i), .dio_l(dio_i), .nrfd_pull(pb_nrfd), .ndac_pull(pb_ndac),
    .dav_pull(pb_dav), .dio_pull(pb_dio), .got_stb(b_stb), .got_cmd(b_cmd), .got_byte(b_byte));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Host streams; the receiver stalls at random so the two-entry buffer fills
  always @(posedge clk_sys) begin
    if (tx_valid && tx_ready) void'(tx_q.pop_front());
    tx_valid <= tx_q.size() > 0;
    tx_data <= tx_q.size() > 0 ? tx_q[0] : 8'h00;
    tx_last <= tx_q.size() == 1;
    if (rx_valid && rx_ready) rx_got.push_back(rx_data);
    rs = lfsr(rs);
    rx_ready <= rs[3] & rs[7];
    if (a_stb && a_cmd) cmd_q.push_back(a_byte);
    if (a_stb && !a_cmd) a_dat.push_back(a_byte);
    if (b_stb && !b_cmd) b_dat.push_back(b_byte);
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Compares a logged byte list, count first, then empties it
  task automatic chk_list(ref logic [7:0] q[$], input logic [7:0] e[$]);
    chk_code(5'(q.size()), 5'(e.size()));
    foreach (e[k]) chk_byte(q[k], e[k]);
    q.delete();
  endtask
  task automatic req(input logic [1:0] kind, input logic adr, input logic [4:0] tgt);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_kind <= kind;
    req_addressed <= adr;
    req_target <= tgt;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask
  task automatic wait_done(input logic [4:0] exp_err);
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (done_pulse !== 1'b1 && i < 3000);
    @(posedge clk_sys);
    chk_code(i < 3000 ? err_code_ff : 5'h1f, exp_err);
  endtask
  task automatic load_tx(input int n);
    exp_q.delete();
    repeat (n) begin
      rnd = lfsr(rnd);
      tx_q.push_back(rnd[7:0]);
      exp_q.push_back(rnd[7:0]);
    end
  endtask
  task automatic do_reset(input logic strap);
    rstn <= 1'b0;
    sys_ctrl_strap <= strap;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    cmd_q.delete();
    rx_got.delete();
    chk_code({4'h0, active_ctrl}, {4'h0, strap});
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset(1'b1);
    req(REQ_OUT, 1'b0, 5'h00);
    wait_done(ERR_NOT_TALKER);
    req(REQ_OUT, 1'b1, 5'h1f);
    wait_done(ERR_BAD_ADDR);
    chk_list(cmd_q, no_q);
    rnd = lfsr(rnd);
    lag_a <= {2'h0, rnd[1:0]};
    load_tx(3 + int'(rnd[3:2]));
    req(REQ_OUT, 1'b1, AA);
    wait_done(ERR_NONE);
    chk_list(cmd_q, '{CMD_UNLISTEN, {GRP_TALK, MY}, {GRP_LISTEN, AA}});
    chk_list(a_dat, exp_q);
    chk_list(b_dat, no_q);
    chk_code({4'h0, talker}, 5'h01);
    req(REQ_LISTEN_ADD, 1'b1, AB);
    wait_done(ERR_NONE);
    chk_list(cmd_q, '{{GRP_LISTEN, AB}});
    load_tx(4);
    req(REQ_OUT, 1'b0, 5'h00);
    wait_done(ERR_NONE);
    chk_list(cmd_q, no_q);
    chk_list(b_dat, exp_q);
    chk_list(a_dat, exp_q);
    req(REQ_IN, 1'b0, 5'h00);
    wait_done(ERR_NOT_LISTEN);
    req(REQ_IN, 1'b1, AA);
    for (int i = 0; i < 3000 && rx_got.size() < 6; i++) @(posedge clk_sys);
    exp_q.delete();
    for (int k = 0; k < 6; k++) exp_q.push_back({3'h5, AA} + 8'(k));
    if (rx_got.size() > 6) rx_got = rx_got[0:5];
    chk_list(cmd_q, '{CMD_UNLISTEN, {GRP_TALK, AA}, {GRP_LISTEN, MY}});
    chk_code({4'h0, listener}, 5'h01);
    chk_code({4'h0, talker}, 5'h00);
    chk_list(rx_got, exp_q);
    do_reset(1'b1);
    req(REQ_PASS, 1'b1, AA);
    wait_done(ERR_NONE);
    chk_list(cmd_q, '{{GRP_TALK, AA}});
    chk_code({4'h0, active_ctrl}, 5'h00);
    req(REQ_OUT, 1'b1, AB);
    repeat (200) @(posedge clk_sys);
    chk_list(cmd_q, no_q);
    do_reset(1'b0);
    summarize();
  end
  // Watchdog: the sequence needs well under 30000 cycles
  initial begin
    #240000;
    n_mismatch++;
    summarize();
  end
endmodule
bind ibac_top ibac_chk ibac_chk_i (.clk_sys, .rstn, .sys_ctrl_strap, .req_valid, .req_ready, .req_kind,
  .req_addressed, .req_target, .rx_valid, .rx_ready, .rx_data, .done_pulse, .err_code_ff, .active_ctrl,
  .dio_oe_n, .atn_oe_n, .dav_oe_n, .nrfd_i, .ndac_i);
